// ===== include/pcm_pkg.sv
// Package for the loop clock multiplier control block.
// Assumes a byte-wide special-function register port on the core clock.
package pcm_pkg;
    localparam logic [7:0] PCM_ADDR_CONTROL = 8'h89;
    localparam logic [7:0] PCM_ADDR_PREDIV = 8'h8d;
    localparam logic [7:0] PCM_ADDR_MULT = 8'h8e;
    localparam logic [7:0] PCM_ADDR_FILTER = 8'h8f;
    localparam logic [7:0] PCM_RST_CONTROL = 8'h00;
    localparam logic [7:0] PCM_RST_PREDIV = 8'h01;
    localparam logic [7:0] PCM_RST_MULT = 8'h01;
    localparam logic [7:0] PCM_RST_FILTER = 8'h31;
    localparam int PCM_BIT_POWER = 0;
    localparam int PCM_BIT_ENABLE = 1;
    localparam int PCM_BIT_SOURCE = 2;
    localparam int PCM_BIT_RSVD = 3;
    localparam int PCM_BIT_LOCK = 4;
    localparam logic [7:0] PCM_MASK_CONTROL = 8'h0f;
    localparam logic [7:0] PCM_MASK_PREDIV = 8'h1f;
    localparam logic [7:0] PCM_MASK_FILTER = 8'h3f;
    localparam logic [8:0] PCM_PREDIV_ZERO = 9'h020;
    localparam logic [8:0] PCM_MULT_ZERO = 9'h100;
    typedef enum logic [2:0] {
        PCM_OFF = 3'b001,
        PCM_ACQUIRE = 3'b010,
        PCM_LOCKED = 3'b100
    } pcm_state_e;
endpackage : pcm_pkg

// ===== design/pcm_ctrl.sv
// Loop clock multiplier control: four byte registers, effective factors, lock flag.
// Assumes the analog loop reports lock on a pin from its own clock domain.
`timescale 1ns/1ps
`default_nettype none
module pcm_ctrl
    import pcm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic loop_locked_raw,
    output logic loop_power,
    output logic loop_reset,
    output logic reference_source_select,
    output logic apply_internal_osc_divide,
    output logic [8:0] predivide_factor,
    output logic [8:0] multiply_factor,
    output logic [3:0] filter_range,
    output logic [1:0] oscillator_range
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] control_q, control_d;
    logic [7:0] prediv_q, prediv_d;
    logic [7:0] mult_q, mult_d;
    logic [7:0] filter_q, filter_d;
    logic [7:0] rdata_q, rdata_d;
    logic lock_s1_q, lock_s2_q;
    pcm_state_e state_q, state_d;
    logic running;
    logic lock_flag;

    assign running = control_q[PCM_BIT_POWER] & control_q[PCM_BIT_ENABLE];
    assign lock_flag = (state_q == PCM_LOCKED) & running;

    always_comb begin
        control_d = control_q;
        prediv_d = prediv_q;
        mult_d = mult_q;
        filter_d = filter_q;
        if (sfr_wr) begin
            case (sfr_addr)
                PCM_ADDR_CONTROL: control_d = sfr_wdata & PCM_MASK_CONTROL;
                PCM_ADDR_PREDIV: prediv_d = sfr_wdata & PCM_MASK_PREDIV;
                PCM_ADDR_MULT: mult_d = sfr_wdata;
                PCM_ADDR_FILTER: filter_d = sfr_wdata & PCM_MASK_FILTER;
                default: ;
            endcase
        end
        rdata_d = rdata_q;
        if (sfr_rd) begin
            case (sfr_addr)
                PCM_ADDR_CONTROL: begin
                    rdata_d = control_q & PCM_MASK_CONTROL;
                    rdata_d[PCM_BIT_LOCK] = lock_flag;
                end
                PCM_ADDR_PREDIV: rdata_d = prediv_q;
                PCM_ADDR_MULT: rdata_d = mult_q;
                PCM_ADDR_FILTER: rdata_d = filter_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            control_q <= PCM_RST_CONTROL;
            prediv_q <= PCM_RST_PREDIV;
            mult_q <= PCM_RST_MULT;
            filter_q <= PCM_RST_FILTER;
            rdata_q <= 8'h00;
        end else begin
            control_q <= control_d;
            prediv_q <= prediv_d;
            mult_q <= mult_d;
            filter_q <= filter_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock tracking
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else begin
            lock_s1_q <= loop_locked_raw;
            lock_s2_q <= lock_s1_q;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            PCM_OFF: if (running) state_d = PCM_ACQUIRE;
            PCM_ACQUIRE: begin
                if (!running) state_d = PCM_OFF;
                else if (lock_s2_q) state_d = PCM_LOCKED;
            end
            PCM_LOCKED: begin
                if (!running) state_d = PCM_OFF;
                else if (!lock_s2_q) state_d = PCM_ACQUIRE;
            end
            default: state_d = PCM_OFF;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= PCM_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to the analog loop
    always_comb begin
        loop_power = control_q[PCM_BIT_POWER];
        loop_reset = ~running;
        reference_source_select = control_q[PCM_BIT_SOURCE];
        apply_internal_osc_divide = ~control_q[PCM_BIT_SOURCE];
        predivide_factor = (prediv_q[4:0] == 5'h00) ? PCM_PREDIV_ZERO
                                                    : {4'h0, prediv_q[4:0]};
        multiply_factor = (mult_q == 8'h00) ? PCM_MULT_ZERO : {1'b0, mult_q};
        filter_range = filter_q[3:0];
        oscillator_range = filter_q[5:4];
    end
    assign sfr_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_lock_off;
        @(posedge clk_sys) disable iff (rst) !running |-> !lock_flag;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("Lock set while off");
    property p_reset_hold;
        @(posedge clk_sys) disable iff (rst) !control_q[PCM_BIT_ENABLE] |-> loop_reset;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("Loop not held");
    property p_power;
        @(posedge clk_sys) disable iff (rst)
            sfr_wr && sfr_addr == PCM_ADDR_CONTROL |=> loop_power == $past(sfr_wdata[PCM_BIT_POWER]);
    endproperty
    a_power: assert property (p_power) else $error("Power mismatch");
    property p_lock_read;
        @(posedge clk_sys) disable iff (rst)
            sfr_rd && sfr_addr == PCM_ADDR_CONTROL |=> sfr_rdata[PCM_BIT_LOCK] == $past(lock_flag);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("Lock read wrong");
    property p_source;
        @(posedge clk_sys) disable iff (rst)
            sfr_wr && sfr_addr == PCM_ADDR_CONTROL
            |=> reference_source_select == $past(sfr_wdata[PCM_BIT_SOURCE])
                && apply_internal_osc_divide != reference_source_select;
    endproperty
    a_source: assert property (p_source) else $error("Source select wrong");
    property p_upper_zero;
        @(posedge clk_sys) disable iff (rst)
            sfr_rd && sfr_addr == PCM_ADDR_CONTROL |=> sfr_rdata[7:5] == 3'b000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("Upper bits set");
    property p_prediv;
        @(posedge clk_sys) disable iff (rst)
            prediv_q[4:0] == 5'h00 |-> predivide_factor == 9'd32;
    endproperty
    a_prediv: assert property (p_prediv) else $error("Divisor zero wrong");
    property p_mult;
        @(posedge clk_sys) disable iff (rst)
            sfr_wr && sfr_addr == PCM_ADDR_MULT && sfr_wdata == 8'h00
            |=> multiply_factor == 9'd256;
    endproperty
    a_mult: assert property (p_mult) else $error("Factor zero wrong");
    property p_lock_rise;
        @(posedge clk_sys) disable iff (rst)
            $rose(lock_flag) |-> $past(running, 2) && running;
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("Lock rose early");
endmodule // pcm_ctrl
`default_nettype wire

// ===== tb/test_pll_clock_multiplier_control.sv
// Self-checking bench for the loop clock multiplier control registers and outputs.
// Assumes pcm_pkg is compiled first; stimulus changes at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module test_pll_clock_multiplier_control
    import pcm_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, loop_locked_raw = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rnd = 8'h11, d;
    logic [7:0] sfr_rdata;
    logic loop_power, loop_reset, reference_source_select, apply_internal_osc_divide;
    logic [8:0] predivide_factor, multiply_factor;
    logic [3:0] filter_range;
    logic [1:0] oscillator_range;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    pcm_ctrl dut (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .loop_locked_raw(loop_locked_raw), .loop_power(loop_power), .loop_reset(loop_reset),
        .reference_source_select(reference_source_select),
        .apply_internal_osc_divide(apply_internal_osc_divide),
        .predivide_factor(predivide_factor), .multiply_factor(multiply_factor),
        .filter_range(filter_range), .oscillator_range(oscillator_range));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [8:0] exp_div(input logic [7:0] v);
        return (v[4:0] == 5'h00) ? 9'h020 : {4'h0, v[4:0]};
    endfunction
    function automatic logic [8:0] exp_mul(input logic [7:0] v);
        return (v == 8'h00) ? 9'h100 : {1'b0, v};
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk({1'b0, sfr_rdata}, {1'b0, e});
    endtask
    task automatic ctl(input logic [7:0] v, input logic [7:0] e);
        wr(PCM_ADDR_CONTROL, v);
        repeat (4) @(negedge clk_sys);
        rd(PCM_ADDR_CONTROL, e);
        chk({8'h00, loop_reset}, {8'h00, ~(v[0] & v[1])});
        chk({8'h00, loop_power}, {8'h00, v[0]});
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        chk({8'h00, loop_reset}, 9'h001);
        chk(predivide_factor, 9'h001);
        chk(multiply_factor, 9'h001);
        chk({3'h0, oscillator_range, filter_range}, 9'h031);
        rd(PCM_ADDR_CONTROL, PCM_RST_CONTROL);
        rd(PCM_ADDR_PREDIV, PCM_RST_PREDIV);
        rd(PCM_ADDR_MULT, PCM_RST_MULT);
        rd(PCM_ADDR_FILTER, PCM_RST_FILTER);
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            d = (i == 0) ? 8'h00 : rnd;
            wr(PCM_ADDR_PREDIV, d);
            chk(predivide_factor, exp_div(d));
            rd(PCM_ADDR_PREDIV, d & 8'h1f);
            rnd = lfsr(rnd);
            d = (i == 1) ? 8'h00 : rnd;
            wr(PCM_ADDR_MULT, d);
            chk(multiply_factor, exp_mul(d));
            rd(PCM_ADDR_MULT, d);
            rnd = lfsr(rnd);
            wr(PCM_ADDR_FILTER, rnd);
            chk({3'h0, oscillator_range, filter_range}, {1'b0, rnd & 8'h3f});
            rd(PCM_ADDR_FILTER, rnd & 8'h3f);
            d = lfsr(rnd) & 8'hf7;
            ctl(d, d & 8'h07);
            chk({7'h00, reference_source_select, apply_internal_osc_divide},
                {7'h00, d[2], ~d[2]});
        end
        loop_locked_raw = 1'b1;
        ctl(8'h02, 8'h02);
        ctl(8'h01, 8'h01);
        ctl(8'h03, 8'h13);
        ctl(8'hf7, 8'h17);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        chk({8'h00, loop_reset}, 9'h001);
        rd(PCM_ADDR_CONTROL, PCM_RST_CONTROL);
        rd(PCM_ADDR_MULT, PCM_RST_MULT);
        ctl(8'h05, 8'h05);
        ctl(8'h03, 8'h13);
        loop_locked_raw = 1'b0;
        repeat (4) @(negedge clk_sys);
        rd(PCM_ADDR_CONTROL, 8'h03);
        wr(8'h8a, 8'hff);
        rd(8'h8a, 8'h00);
        rd(PCM_ADDR_CONTROL, 8'h03);
        ctl(8'h00, 8'h00);
        // Power-up, reconfigure and shut down; flash timing steps sit outside the block
        wr(PCM_ADDR_CONTROL, 8'h04);
        wr(PCM_ADDR_CONTROL, 8'h05);
        wr(PCM_ADDR_PREDIV, 8'h05);
        wr(PCM_ADDR_FILTER, 8'h1f);
        wr(PCM_ADDR_MULT, 8'h10);
        repeat (200) @(negedge clk_sys);
        wr(PCM_ADDR_CONTROL, 8'h07);
        rd(PCM_ADDR_CONTROL, 8'h07);
        loop_locked_raw = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(PCM_ADDR_CONTROL, 8'h17);
        chk(predivide_factor, 9'h005);
        chk(multiply_factor, 9'h010);
        chk({8'h00, apply_internal_osc_divide}, 9'h000);
        wr(PCM_ADDR_CONTROL, 8'h03);
        wr(PCM_ADDR_CONTROL, 8'h01);
        loop_locked_raw = 1'b0;
        rd(PCM_ADDR_CONTROL, 8'h01);
        wr(PCM_ADDR_PREDIV, 8'h00);
        chk(predivide_factor, 9'h020);
        wr(PCM_ADDR_FILTER, 8'h31);
        wr(PCM_ADDR_MULT, 8'h00);
        chk(multiply_factor, 9'h100);
        wr(PCM_ADDR_CONTROL, 8'h03);
        loop_locked_raw = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(PCM_ADDR_CONTROL, 8'h13);
        wr(PCM_ADDR_CONTROL, 8'h00);
        rd(PCM_ADDR_CONTROL, 8'h00);
        report_and_stop();
    end
endmodule // test_pll_clock_multiplier_control
`default_nettype wire
